// file: hdl/eps_regs.svh
`ifndef EPS_REGS_SVH
`define EPS_REGS_SVH

// register byte offsets on the apb bus
`define EPS_CTRL_OFS      8'h00
`define EPS_PERIOD_OFS    8'h04
`define EPS_DUTY_OFS      8'h08
`define EPS_DEAD_OFS      8'h0C
`define EPS_TMRCFG_OFS    8'h10
`define EPS_DIR_OFS       8'h14
`define EPS_STATUS_OFS    8'h18

// reset values
`define EPS_CTRL_RST      8'h00
`define EPS_PERIOD_RST    8'hFF
`define EPS_DUTY_RST      8'h00
`define EPS_DEAD_RST      7'h00
`define EPS_TMRCFG_RST    7'h00
`define EPS_DIR_RST       4'h0

// field positions
`define EPS_ST_TIMER_LSB  0
`define EPS_ST_LATCH_LSB  8
`define EPS_ST_RUN_BIT    18
`define EPS_ST_PINS_LSB   19
`define EPS_ST_POST_BIT   23
`define EPS_PWM_MODE      2'h3

// timing: sys_clk is the oscillator, one instruction cycle is 4 tosc
`define EPS_TOSC_NS        20
`define EPS_CLK_NS         20
`define EPS_TOSC_PER_TCY   4
`define EPS_ENH_DELAY_TOSC 4
`define EPS_ENH_DELAY_CYC  ((`EPS_ENH_DELAY_TOSC*`EPS_TOSC_NS)/`EPS_CLK_NS)

`endif

// file: hdl/eps_pkg.sv
package eps_pkg;

    // capture/compare control word as software sees it
    typedef struct packed {
        logic [1:0] output_steering_mode; // bridge steering
        logic [1:0] duty_lsb;             // two fine duty bits
        logic [3:0] capture_compare_mode_sel; // 11xx selects pwm
    } eps_ctrl_t;

    // period timer configuration
    typedef struct packed {
        logic [3:0] post_sel;  // postscale count minus one
        logic [1:0] ps_sel;    // 00 /1, 01 /4, 1x /16
        logic       on;        // timer runs
    } eps_tb_cfg_t;

    // last prescaler count before an increment
    function automatic logic [3:0] eps_pre_limit(input logic [1:0] sel);
        eps_pre_limit = (sel == 2'h0) ? 4'h0 :
                        (sel == 2'h1) ? 4'h3 : 4'hF;
    endfunction : eps_pre_limit

endpackage : eps_pkg

// file: hdl/eps_timebase.sv
`timescale 1ns/10ps
`default_nettype none
`include "eps_regs.svh"

module eps_timebase (
    input  wire logic               sys_clk_in,     // oscillator clock
    input  wire logic               reset_n_in,     // async reset, low
    input  wire eps_pkg::eps_tb_cfg_t cfg_in,       // timer config
    input  wire logic [7:0]         period_in,      // active period
    output logic [7:0]              timer_out,      // period timer
    output logic [1:0]              fine_out,       // sub-count bits
    output logic                    tcy_tick_out,   // instruction tick
    output logic                    boundary_out,   // period restart
    output logic                    post_evt_out    // postscaled event
);
    logic [1:0] q_reg;     // tosc phase in the instruction cycle
    logic [3:0] pre_reg;   // prescaler
    logic [7:0] tmr_reg;   // period timer
    logic [3:0] post_reg;  // postscaler
    logic       bnd_reg;   // boundary pulse
    logic       pev_reg;   // postscaler pulse

    wire [3:0] pre_lim = eps_pkg::eps_pre_limit(cfg_in.ps_sel);
    wire       tcy     = cfg_in.on && (q_reg == 2'h3);
    wire       inc     = tcy && (pre_reg == pre_lim);
    wire       match   = (tmr_reg == period_in);

    // timer counts (period+1) * 4 tosc * prescale per cycle
    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            q_reg <= 2'h0;
            pre_reg <= 4'h0;
            tmr_reg <= 8'h00;
            bnd_reg <= 1'b0;
        end
        else if (!cfg_in.on)
        begin
            // stopped timer restarts cleanly from zero
            q_reg <= 2'h0;
            pre_reg <= 4'h0;
            tmr_reg <= 8'h00;
            bnd_reg <= 1'b0;
        end
        else
        begin
            q_reg <= q_reg + 2'h1;
            if (tcy)
                pre_reg <= (pre_reg == pre_lim) ? 4'h0 : pre_reg + 4'h1;
            if (inc)
                tmr_reg <= match ? 8'h00 : tmr_reg + 8'h01;
            bnd_reg <= inc && match;
        end
    end

    // postscaler only paces the update event, never the period
    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            post_reg <= 4'h0;
            pev_reg <= 1'b0;
        end
        else
        begin
            pev_reg <= bnd_reg && (post_reg == cfg_in.post_sel);
            if (bnd_reg)
                post_reg <= (post_reg == cfg_in.post_sel) ? 4'h0
                                                          : post_reg + 4'h1;
        end
    end

    assign timer_out    = tmr_reg;
    assign fine_out     = (cfg_in.ps_sel == 2'h0) ? q_reg :
                          (cfg_in.ps_sel == 2'h1) ? pre_reg[1:0] : pre_reg[3:2];
    assign tcy_tick_out = tcy;
    assign boundary_out = bnd_reg;
    assign post_evt_out = pev_reg;
endmodule : eps_timebase
`default_nettype wire

// file: hdl/eps_out_stage.sv
`timescale 1ns/10ps
`default_nettype none
`include "eps_regs.svh"

module eps_out_stage (
    input  wire logic             sys_clk_in,   // oscillator clock
    input  wire logic             reset_n_in,   // async reset, low
    input  wire logic             run_in,       // waveform running
    input  wire logic             raw_in,       // modulated level
    input  wire logic             tcy_tick_in,  // instruction tick
    input  wire eps_pkg::eps_ctrl_t ctrl_in,    // active control copy
    input  wire logic [6:0]       dead_in,      // active dead band
    output logic [3:0]            pins_out      // d,c,b,a pin levels
);
    localparam int DLY = `EPS_ENH_DELAY_CYC;

    logic [DLY-1:0] dly_reg;      // one instruction cycle of delay
    logic           prev_reg;     // delayed level last cycle
    logic [6:0]     dead_cnt_reg; // dead band remaining
    logic [3:0]     pins_reg;     // registered pin levels
    logic [3:0]     act;          // active-high pin wish

    wire pwm   = dly_reg[DLY-1];
    wire edg   = pwm ^ prev_reg;
    wire busy  = (edg && (dead_in != 7'h00)) || (dead_cnt_reg != 7'h00);
    // polarity: bit1 high makes a,c active low, bit0 does b,d
    wire ac_lo = ctrl_in.capture_compare_mode_sel[1];
    wire bd_lo = ctrl_in.capture_compare_mode_sel[0];
    wire [3:0] pol = {bd_lo, ac_lo, bd_lo, ac_lo};

    // steering per output mode, d c b a order
    always_comb
    begin
        case (ctrl_in.output_steering_mode)
            2'h0: act = {3'b000, pwm};                 // single output
            2'h1: act = {pwm, 2'b00, 1'b1};            // forward bridge
            2'h2: act = {2'b00, ~pwm & ~busy, pwm & ~busy}; // half bridge
            2'h3: act = {1'b0, 1'b1, pwm, 1'b0};       // reverse bridge
            default: act = 4'h0;
        endcase
    end

    // delay line, dead band counter and pin registers
    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            dly_reg <= '0;
            prev_reg <= 1'b0;
            dead_cnt_reg <= 7'h00;
            pins_reg <= 4'h0;
        end
        else
        begin
            dly_reg <= {dly_reg[DLY-2:0], raw_in & run_in};
            prev_reg <= pwm;
            if (edg)
                dead_cnt_reg <= dead_in;
            else if (tcy_tick_in && dead_cnt_reg != 7'h00)
                dead_cnt_reg <= dead_cnt_reg - 7'h01;
            // idle pins rest at their inactive level
            pins_reg <= run_in ? (act ^ pol) : pol;
        end
    end

    assign pins_out = pins_reg;
endmodule : eps_out_stage
`default_nettype wire

// file: hdl/eps_pwm_top.sv
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "eps_regs.svh"

module eps_pwm_top (
    input  wire logic        sys_clk_in,    // oscillator clock, 50 mhz
    input  wire logic        reset_n_in,    // async reset, active low
    input  wire logic        psel_in,       // apb select
    input  wire logic        penable_in,    // apb enable
    input  wire logic        pwrite_in,     // apb write
    input  wire logic [7:0]  paddr_in,      // apb byte address
    input  wire logic [31:0] pwdata_in,     // apb write data
    output logic [31:0]      prdata_out,    // apb read data
    output logic             pready_out,    // apb ready
    output logic             pslverr_out,   // apb error, unmapped
    output logic             pwm_out_a,     // pwm output a
    output logic             pwm_out_b,     // pwm output b
    output logic             pwm_out_c,     // pwm output c
    output logic             pwm_out_d,     // pwm output d
    output logic [3:0]       pwm_oe_out,    // pin output enables d..a
    output logic             update_evt_out // postscaled update pulse
);

    // software-visible registers
    eps_pkg::eps_ctrl_t    ctrl_reg;           // written control
    logic [7:0]            period_reg;         // written period
    logic [7:0]            duty_write_reg;     // written duty msbs
    logic [6:0]            deadband_delay_reg; // written dead band
    eps_pkg::eps_tb_cfg_t  tmr_cfg_reg;        // timer config
    logic [3:0]            pin_direction_bits_reg; // 1 drives pin
    logic                  post_flag_reg;      // sticky update flag

    // active copies used by the waveform logic
    eps_pkg::eps_ctrl_t    ctrl_act_reg;       // active control
    logic [7:0]            period_act_reg;     // active period
    logic [9:0]            duty_active_latch_reg; // compared duty
    logic [6:0]            dead_act_reg;       // active dead band

    // waveform state
    logic                  run_reg;            // waveform running
    logic                  raw_reg;            // modulated level

    // apb answer registers
    logic [31:0]           prdata_reg;         // read data
    logic                  pready_reg;         // ready
    logic                  pslverr_reg;        // error
    logic                  evt_reg;            // update pulse out

    // timebase and output stage wires
    logic [7:0]            timer_w;            // period timer value
    logic [1:0]            fine_w;             // sub-count bits
    logic                  tcy_tick_w;         // instruction tick
    logic                  boundary_w;         // period restart
    logic                  post_evt_w;         // postscaled event
    logic [3:0]            pins_w;             // pin levels d..a

    // apb decode: setup phase samples, access phase completes
    wire setup    = psel_in && !penable_in;
    wire access   = psel_in && penable_in && pready_reg;
    wire wr_acc   = access && pwrite_in && !pslverr_reg;

    wire hit_ctrl   = (paddr_in == `EPS_CTRL_OFS);
    wire hit_period = (paddr_in == `EPS_PERIOD_OFS);
    wire hit_duty   = (paddr_in == `EPS_DUTY_OFS);
    wire hit_dead   = (paddr_in == `EPS_DEAD_OFS);
    wire hit_tmr    = (paddr_in == `EPS_TMRCFG_OFS);
    wire hit_dir    = (paddr_in == `EPS_DIR_OFS);
    wire hit_stat   = (paddr_in == `EPS_STATUS_OFS);
    wire mapped     = hit_ctrl | hit_period | hit_duty | hit_dead |
                      hit_tmr | hit_dir | hit_stat;

    // pwm mode is the 11xx family of the mode select field
    wire pwm_sel_w  = (ctrl_reg.capture_compare_mode_sel[3:2]
                       == `EPS_PWM_MODE);

    // ten-bit duty that will be latched at the next boundary
    wire [9:0] duty_new = {duty_write_reg, ctrl_reg.duty_lsb};
    // timer extended with its two sub-count bits
    wire [9:0] cmp_val  = {timer_w, fine_w};
    wire       duty_hit = run_reg && (cmp_val == duty_active_latch_reg);

    // status word assembled from the block's own state
    wire [31:0] status_w = {8'h00, post_flag_reg, pins_w, run_reg,
                            duty_active_latch_reg, timer_w};

    // read mux, evaluated in the setup phase
    wire [31:0] rd_mux =
        hit_ctrl   ? {24'h0, ctrl_reg} :
        hit_period ? {24'h0, period_reg} :
        hit_duty   ? {24'h0, duty_write_reg} :
        hit_dead   ? {25'h0, deadband_delay_reg} :
        hit_tmr    ? {25'h0, tmr_cfg_reg} :
        hit_dir    ? {28'h0, pin_direction_bits_reg} :
        hit_stat   ? status_w : 32'h0;

    // write to status with a one at the flag bit clears it
    wire flag_clr = wr_acc && hit_stat && pwdata_in[`EPS_ST_POST_BIT];

    // apb answer: zero wait states, data captured during setup
    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            prdata_reg <= 32'h0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            pready_reg <= setup;
            pslverr_reg <= setup && !mapped;
            if (setup)
                prdata_reg <= pwrite_in ? 32'h0 : rd_mux;
        end
    end

    // software register writes
    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            ctrl_reg <= `EPS_CTRL_RST;
            period_reg <= `EPS_PERIOD_RST;
            duty_write_reg <= `EPS_DUTY_RST;
            deadband_delay_reg <= `EPS_DEAD_RST;
            tmr_cfg_reg <= `EPS_TMRCFG_RST;
            pin_direction_bits_reg <= `EPS_DIR_RST;
        end
        else if (wr_acc)
        begin
            if (hit_ctrl)
                ctrl_reg <= pwdata_in[7:0];
            if (hit_period)
                period_reg <= pwdata_in[7:0];
            if (hit_duty)
                duty_write_reg <= pwdata_in[7:0];
            if (hit_dead)
                deadband_delay_reg <= pwdata_in[6:0];
            if (hit_tmr)
                tmr_cfg_reg <= pwdata_in[6:0];
            // the block never turns pins around on its own
            if (hit_dir)
                pin_direction_bits_reg <= pwdata_in[3:0];
        end
    end

    // sticky update flag: a new event beats a same-cycle clear
    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            post_flag_reg <= 1'b0;
        else if (post_evt_w)
            post_flag_reg <= 1'b1;
        else if (flag_clr)
            post_flag_reg <= 1'b0;
    end

    // double buffers: while the timer runs, active copies move only at the period boundary,
    // so a write mid-period cannot glitch a pin
    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            ctrl_act_reg <= `EPS_CTRL_RST;
            period_act_reg <= `EPS_PERIOD_RST;
            duty_active_latch_reg <= 10'h000;
        end
        else if (boundary_w || !tmr_cfg_reg.on)
        begin
            // a stopped timer has no boundary, so copies follow freely
            ctrl_act_reg <= ctrl_reg;
            period_act_reg <= period_reg;
            duty_active_latch_reg <= duty_new;
        end
    end

    // dead band takes whichever boundary comes first
    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            dead_act_reg <= `EPS_DEAD_RST;
        else if (boundary_w || duty_hit || !tmr_cfg_reg.on)
            dead_act_reg <= deadband_delay_reg;
    end

    // run starts only at a timer reset, stops at once on disable
    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            run_reg <= 1'b0;
        else if (!pwm_sel_w || !tmr_cfg_reg.on)
            run_reg <= 1'b0;
        else if (boundary_w)
            run_reg <= 1'b1;
    end

    // modulated level: set at period start, cleared at duty match
    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            raw_reg <= 1'b0;
        else if (!pwm_sel_w || !tmr_cfg_reg.on)
            raw_reg <= 1'b0;
        else if (boundary_w)
            // zero duty keeps the output deasserted all period
            raw_reg <= (duty_new != 10'h000);
        else if (duty_hit)
            raw_reg <= 1'b0;
    end

    // update pulse straight from a flop
    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            evt_reg <= 1'b0;
        else
            evt_reg <= post_evt_w;
    end

    // period timer with prescaler and postscaler
    eps_timebase u_timebase (
        .sys_clk_in   (sys_clk_in),
        .reset_n_in   (reset_n_in),
        .cfg_in       (tmr_cfg_reg),
        .period_in    (period_act_reg),
        .timer_out    (timer_w),
        .fine_out     (fine_w),
        .tcy_tick_out (tcy_tick_w),
        .boundary_out (boundary_w),
        .post_evt_out (post_evt_w)
    );

    // steering, polarity, dead band and one instruction cycle offset
    eps_out_stage u_out_stage (
        .sys_clk_in  (sys_clk_in),
        .reset_n_in  (reset_n_in),
        .run_in      (run_reg),
        .raw_in      (raw_reg),
        .tcy_tick_in (tcy_tick_w),
        .ctrl_in     (ctrl_act_reg),
        .dead_in     (dead_act_reg),
        .pins_out    (pins_w)
    );

    // outputs, each from a flop
    assign prdata_out     = prdata_reg;
    assign pready_out     = pready_reg;
    assign pslverr_out    = pslverr_reg;
    assign pwm_out_a      = pins_w[0];
    assign pwm_out_b      = pins_w[1];
    assign pwm_out_c      = pins_w[2];
    assign pwm_out_d      = pins_w[3];
    assign pwm_oe_out     = pin_direction_bits_reg;
    assign update_evt_out = evt_reg;

endmodule : eps_pwm_top
`default_nettype wire

// file: bench/eps_switch_model.sv
`timescale 1ns/10ps
`default_nettype none

module eps_switch_model (
    input  wire logic [3:0] pins_in,  // pin levels d..a
    input  wire logic [3:0] oe_in,    // pin enables d..a
    output logic      [3:0] gate_out  // gate level seen by each switch
);
    // an undriven pin floats, so the gate pull-down keeps that switch off
    assign gate_out = pins_in & oe_in;
endmodule : eps_switch_model

`default_nettype wire

// file: bench/eps_pwm_properties.sv
`timescale 1ns/10ps
`default_nettype none
`include "eps_regs.svh"

module eps_pwm_properties (
    input wire logic        sys_clk_in,    // clock
    input wire logic        reset_n_in,    // reset, low
    input wire logic        psel_in,       // apb select
    input wire logic        penable_in,    // apb enable
    input wire logic        pwrite_in,     // apb write
    input wire logic [7:0]  paddr_in,      // apb address
    input wire logic [31:0] pwdata_in,     // apb write data
    input wire logic [31:0] prdata_out,    // apb read data
    input wire logic        pready_out,    // apb ready
    input wire logic        pslverr_out,   // apb error
    input wire logic        pwm_out_a,     // pin a
    input wire logic [3:0]  pwm_oe_out,    // pin enables
    input wire logic        update_evt_out // update pulse
);
    default clocking @(posedge sys_clk_in);
    endclocking
    default disable iff (!reset_n_in);
    logic [7:0]  ctl_q, per_q, dty_q; // written ctrl, period, duty
    logic [2:0]  cfg_q;               // written prescale and on bits
    logic [15:0] cnt_q;               // cycles since pin a rose
    logic [1:0]  nrise_q;             // rises since last write
    logic        act_q;               // pin a active a cycle ago
    wire wr = psel_in & penable_in & pready_out & pwrite_in;
    wire act = pwm_out_a ^ ctl_q[1];  // mode bit 1 inverts pin a
    wire rise = act & ~act_q;
    wire fall = ~act & act_q;
    wire [15:0] pre = (cfg_q[2:1] == 2'h0) ? 16'h1 :
                      (cfg_q[2:1] == 2'h1) ? 16'h4 : 16'h10;
    wire [15:0] exp_per = ({8'h00, per_q} + 16'h1) * pre * 16'h4;
    wire [15:0] exp_wid = {6'h00, dty_q, ctl_q[5:4]} * pre;

    // shadow what shapes pin a
    always_ff @(posedge sys_clk_in or negedge reset_n_in)
        if (!reset_n_in)
        begin
            ctl_q <= 8'h00;
            per_q <= 8'hFF;
            dty_q <= 8'h00;
            cfg_q <= 3'h0;
        end
        else if (wr && paddr_in == `EPS_CTRL_OFS)
            ctl_q <= pwdata_in[7:0];
        else if (wr && paddr_in == `EPS_PERIOD_OFS)
            per_q <= pwdata_in[7:0];
        else if (wr && paddr_in == `EPS_DUTY_OFS)
            dty_q <= pwdata_in[7:0];
        else if (wr && paddr_in == `EPS_TMRCFG_OFS)
            cfg_q <= pwdata_in[2:0];

    // a write restarts the rise count
    always_ff @(posedge sys_clk_in or negedge reset_n_in)
        if (!reset_n_in)
        begin
            act_q   <= 1'b0;
            cnt_q   <= 16'h0;
            nrise_q <= 2'h0;
        end
        else
        begin
            act_q   <= act;
            cnt_q   <= rise ? 16'h1 : cnt_q + 16'h1;
            nrise_q <= wr ? 2'h0 : nrise_q + {1'b0, rise && nrise_q != 2'h3};
        end

    a_ready_follows: assert property (psel_in && !penable_in |=> pready_out)
        else $error("no ready after setup");
    a_ready_single: assert property (pready_out |=> !pready_out)
        else $error("ready held too long");
    a_err_unmapped: assert property (pready_out && !pwrite_in &&
        paddr_in >= 8'h1C |-> pslverr_out && prdata_out == 32'h0)
        else $error("unmapped read");
    a_err_alone: assert property (pslverr_out |-> pready_out)
        else $error("error without ready");
    a_oe_follows: assert property (wr && paddr_in == `EPS_DIR_OFS |=>
        pwm_oe_out == $past(pwdata_in[3:0]))
        else $error("enables wrong");
    a_evt_single: assert property (update_evt_out |=> !update_evt_out)
        else $error("update pulse too long");
    a_period_len: assert property (rise && nrise_q == 2'h3 |->
        cnt_q == exp_per)
        else $error("pwm period wrong");
    a_high_width: assert property (fall && nrise_q == 2'h3 |->
        cnt_q == exp_wid)
        else $error("pwm active width wrong");
endmodule : eps_pwm_properties

bind eps_pwm_top eps_pwm_properties u_props (.sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .pwm_out_a(pwm_out_a),
    .pwm_oe_out(pwm_oe_out), .update_evt_out(update_evt_out));

`default_nettype wire

// file: bench/eps_pwm_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "eps_regs.svh"

module eps_pwm_bench;
    logic        sys_clk_in = 1'b0;  // 50 mhz clock
    logic        reset_n_in = 1'b0;  // reset, active low
    logic        psel_in    = 1'b0;  // apb select
    logic        penable_in = 1'b0;  // apb enable
    logic        pwrite_in  = 1'b0;  // apb direction
    logic [7:0]  paddr_in   = 8'h00; // apb address
    logic [31:0] pwdata_in  = 32'h0; // apb write data
    wire  [31:0] prdata_out;         // apb read data
    wire         pready_out, pslverr_out, pwm_out_a, pwm_out_b;
    wire         pwm_out_c, pwm_out_d, update_evt_out;
    wire  [3:0]  pwm_oe_out, gate;   // pin enables, switch gates
    logic        pol = 1'b0;         // pin a is active low
    logic [31:0] rd;                 // last read word
    logic        er;                 // last error flag
    int          n_errors = 0;       // mismatches
    int          cmp_count = 0;      // comparisons
    wire act = pwm_out_a ^ pol;      // pin a at its active level
    wire [3:0] pins = {pwm_out_d, pwm_out_c, pwm_out_b, pwm_out_a};

    always #10 sys_clk_in = ~sys_clk_in;

    eps_pwm_top uut (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
        .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out),
        .pwm_out_a(pwm_out_a), .pwm_out_b(pwm_out_b), .pwm_out_c(pwm_out_c),
        .pwm_out_d(pwm_out_d), .pwm_oe_out(pwm_oe_out),
        .update_evt_out(update_evt_out));
    eps_switch_model far (.pins_in(pins), .oe_in(pwm_oe_out), .gate_out(gate));

    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    task automatic hang;
        n_errors++;
        report_and_stop;
    endtask : hang

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n = 0;
        @(posedge sys_clk_in);
        psel_in   <= 1'b1;
        pwrite_in <= w;
        paddr_in  <= a;
        pwdata_in <= d;
        @(posedge sys_clk_in);
        penable_in <= 1'b1;
        @(posedge sys_clk_in);
        while (pready_out !== 1'b1 && n < 16)
        begin
            @(posedge sys_clk_in);
            n++;
        end
        if (n >= 16)
            hang;
        rd = prdata_out;
        er = pslverr_out;
        psel_in    <= 1'b0;
        penable_in <= 1'b0;
    endtask : apb

    task automatic wt(input logic v);
        int n = 0;
        while (act !== v && n < 20000)
        begin
            @(posedge sys_clk_in);
            n++;
        end
        if (n >= 20000)
            hang;
    endtask : wt

    // pin a inactive for n cycles
    task automatic quiet(input int n);
        logic hi = 1'b0;
        repeat (n)
        begin
            @(posedge sys_clk_in);
            hi = hi | (act !== 1'b0);
        end
        chk({31'h0, hi}, 32'h0);
    endtask : quiet

    // time one active phase and one period
    task automatic meas(input int per, input int wid);
        int h, t;
        repeat (4)
        begin
            wt(1'b0);
            wt(1'b1);
        end
        h = 0;
        t = 0;
        while (!(act === 1'b1 && h != 0) && t < 20000)
        begin
            @(posedge sys_clk_in);
            t++;
            if (act !== 1'b1 && h == 0)
                h = t;
        end
        chk(32'(h), 32'(wid));
        chk(32'(t), 32'(per));
    endtask : meas

    // stop the timer first so the new values load cleanly
    task automatic setup(input logic [7:0] p, input logic [9:0] d,
                         input logic [3:0] m, input logic [6:0] c);
        apb(1'b1, `EPS_TMRCFG_OFS, 32'h0);
        apb(1'b1, `EPS_PERIOD_OFS, {24'h0, p});
        apb(1'b1, `EPS_DUTY_OFS, {24'h0, d[9:2]});
        apb(1'b1, `EPS_CTRL_OFS, {24'h0, 2'h0, d[1:0], m});
        apb(1'b1, `EPS_TMRCFG_OFS, {25'h0, c});
    endtask : setup

    task automatic t_regs;
        logic [31:0] rv [6] = '{32'(`EPS_CTRL_RST), 32'(`EPS_PERIOD_RST),
            32'(`EPS_DUTY_RST), 32'(`EPS_DEAD_RST), 32'(`EPS_TMRCFG_RST),
            32'(`EPS_DIR_RST)};
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk(rd, rv[i]);
        end
        apb(1'b1, `EPS_DEAD_OFS, 32'hFFFF_FFFF);
        apb(1'b0, `EPS_DEAD_OFS, 32'h0);
        chk(rd, 32'h0000_007F);
        apb(1'b1, `EPS_DIR_OFS, 32'hFFFF_FFFF);
        @(posedge sys_clk_in);
        chk({28'h0, pwm_oe_out}, 32'hF);
        apb(1'b0, 8'h1C, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
    endtask : t_regs

    // first enable, then a mid-period duty change
    task automatic t_buf;
        setup(8'h09, 10'h004, 4'hC, 7'h01);
        quiet(30);
        wt(1'b0);
        wt(1'b1);
        apb(1'b1, `EPS_DUTY_OFS, 32'h0);
        apb(1'b0, `EPS_STATUS_OFS, 32'h0);
        chk({22'h0, rd[17:8]}, 32'h4);
        repeat (40) @(posedge sys_clk_in);
        apb(1'b0, `EPS_STATUS_OFS, 32'h0);
        chk({22'h0, rd[17:8]}, 32'h0);
        quiet(100);
    endtask : t_buf

    // each prescale; the postscaler must not stretch it
    task automatic t_wave;
        logic [7:0] pv [3] = '{8'h01, 8'h03, 8'h02};
        logic [1:0] sv [3] = '{2'h0, 2'h1, 2'h2};
        logic [9:0] dv [3] = '{10'h004, 10'h005, 10'h003};
        int         mv [3] = '{1, 4, 16};
        for (int i = 0; i < 3; i++)
        begin
            setup(pv[i], dv[i], 4'hC, {4'h3, sv[i], 1'b1});
            meas((pv[i] + 1) * 4 * mv[i], dv[i] * mv[i]);
        end
    endtask : t_wave

    // active-low pins and switch gates
    task automatic t_pol;
        pol = 1'b1;
        setup(8'h01, 10'h004, 4'hF, 7'h01);
        meas(8, 4);
        chk({29'h0, pins[3:1]}, 32'h7);
        chk({28'h0, gate}, {28'h0, pins});
        apb(1'b1, `EPS_DIR_OFS, 32'h0);
        @(posedge sys_clk_in);
        chk({28'h0, gate}, 32'h0);
    endtask : t_pol

    initial
    begin
        repeat (5) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        t_regs;
        t_buf;
        t_wave;
        t_pol;
        report_and_stop;
    end
endmodule : eps_pwm_bench

`default_nettype wire
